// ### ubw_pkg.sv
package ubw_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_BUF_CTL = 8'h38;
    localparam logic [7:0] OFS_BUF_STAT = 8'h3C;
    localparam logic [7:0] OFS_WAKE_CTL = 8'h54;
    localparam logic [7:0] OFS_WAKE_STAT = 8'h58;
    localparam logic [7:0] OFS_IRQSTS = 8'h60;
    localparam logic [7:0] OFS_IRQMSK = 8'h64;

    // field positions
    localparam int BIT_RX_EMPTY = 0;
    localparam int BIT_RX_FULL = 1;
    localparam int BIT_RX_OVR = 3;
    localparam int BIT_TX_EMPTY = 8;
    localparam int BIT_TX_FULL = 9;
    localparam int BIT_OVR_IEN = 14;
    localparam int BIT_WK_EN = 0;
    localparam int BIT_PD_BLOCK = 2;
    localparam int BIT_WK_FLAG = 0;
    localparam int BIT_IRQ_OVR = 0;
    localparam int BIT_IRQ_WAKE = 1;

    // values after reset
    localparam logic [31:0] BUF_STAT_RST = 32'h0000_0101;
    localparam logic [31:0] WAKE_CTL_RST = 32'h0000_0000;

    // buffer depth in words
    localparam int BUF_DEPTH = 2;
    localparam int CNT_W = 2;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_IDLE = 2'b01,
        PWR_DOWN = 2'b10
    } ubw_pwr_e;

endpackage

// ### ubw_buf_level.sv
`timescale 1ns/1ps
module ubw_buf_level
    import ubw_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic push_i,
    input wire logic pop_i,
    output logic empty_o,
    output logic full_o,
    output logic overrun_o
);

    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic empty_q;
    logic full_q;
    logic overrun_q;

    localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(BUF_DEPTH);
    localparam logic [CNT_W-1:0] ONE_C = CNT_W'(1);

    // a push into a full buffer is dropped; a pop in the same cycle frees room first
    wire push_ok = push_i && (!full_q || pop_i);
    wire pop_ok = pop_i && !empty_q;
    wire ovr_evt = push_i && full_q && !pop_i;

    always_comb begin
        count_d = count_q;
        if (push_ok && !pop_ok) begin
            count_d = count_q + ONE_C;
        end else if (pop_ok && !push_ok) begin
            count_d = count_q - ONE_C;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            count_q <= '0;
            empty_q <= 1'b1;
            full_q <= 1'b0;
            overrun_q <= 1'b0;
        end else begin
            count_q <= count_d;
            empty_q <= (count_d == '0);
            full_q <= (count_d == DEPTH_C);
            overrun_q <= ovr_evt;
        end
    end

    assign empty_o = empty_q;
    assign full_o = full_q;
    assign overrun_o = overrun_q;

    a_ovr_keeps_count: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ovr_evt |=> (count_q == $past(count_q)) && overrun_q)
        else $error("overrun changed buffer contents");

    a_full_level: assert property (@(posedge core_clk_i) disable iff (reset_i)
        full_q == (count_q == DEPTH_C))
        else $error("full flag disagrees with level");

    a_empty_level: assert property (@(posedge core_clk_i) disable iff (reset_i)
        empty_q == (count_q == '0))
        else $error("empty flag disagrees with level");

endmodule // ubw_buf_level

// ### ubw_status_wakeup.sv
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Operation
// - transmit full bit is high exactly while the transmit buffer has no room
// - transmit empty bit is high exactly while no transmit data is pending
// - status resets with both empty bits set, full bits and overrun clear
// - receive full bit is high exactly while no further received word fits
// - receive empty bit is high exactly while no unread received word remains
// - overrun flag sets on an overrun event and stays until software clears
// - interrupt asserted while overrun flag and its interrupt enable are both set
// - writing one clears the overrun flag; writing zero leaves it alone
// - blocking option clear: power-down during transfer aborts it, enters power-down
// - blocking option set: power-down during transfer keeps it running, enters idle
// - wake-up happens only while the wake-up enable bit is one
// - waking from power-down sets the wake-up flag; write one clears it
module ubw_status_wakeup
    import ubw_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic tx_push_i,
    input wire logic tx_pop_i,
    input wire logic rx_push_i,
    input wire logic rx_pop_i,
    input wire logic powerdown_req_i,
    input wire logic transfer_active_i,
    input wire logic wake_pin_i,
    output logic irq_o,
    output logic powerdown_o,
    output logic idle_o,
    output logic transfer_abort_o,
    output logic chip_wake_o
);

    ////////////////////////////////////////////////////////////////////////////
    // buffer levels

    logic tx_buf_drained;
    logic tx_buf_no_room;
    logic rx_buf_drained;
    logic rx_buf_no_room;
    logic rx_overrun_evt;

    ubw_buf_level u_tx_level (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .push_i(tx_push_i),
        .pop_i(tx_pop_i),
        .empty_o(tx_buf_drained),
        .full_o(tx_buf_no_room),
        .overrun_o()
    );

    ubw_buf_level u_rx_level (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .push_i(rx_push_i),
        .pop_i(rx_pop_i),
        .empty_o(rx_buf_drained),
        .full_o(rx_buf_no_room),
        .overrun_o(rx_overrun_evt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus slave

    logic aw_held_q;
    logic w_held_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    function automatic logic known_ofs(input logic [7:0] a);
        return (a == OFS_BUF_CTL) || (a == OFS_BUF_STAT) || (a == OFS_WAKE_CTL) ||
               (a == OFS_WAKE_STAT) || (a == OFS_IRQSTS) || (a == OFS_IRQMSK);
    endfunction

    wire aw_hs = s_axi_awvalid && awready_q;
    wire w_hs = s_axi_wvalid && wready_q;
    wire aw_have = aw_held_q || aw_hs;
    wire w_have = w_held_q || w_hs;
    wire b_issue = aw_have && w_have && !bvalid_q;
    wire aw_held_d = aw_have && !b_issue;
    wire w_held_d = w_have && !b_issue;
    wire bvalid_d = (bvalid_q && !s_axi_bready) || b_issue;
    wire [7:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
    wire [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
    // bytes 0 and 1 hold every live field
    wire [31:0] wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire [31:0] wr_bits = wr_data & wr_mask;
    wire wr_buf_ctl = b_issue && (wr_addr == OFS_BUF_CTL);
    wire wr_buf_stat = b_issue && (wr_addr == OFS_BUF_STAT);
    wire wr_wake_ctl = b_issue && (wr_addr == OFS_WAKE_CTL);
    wire wr_wake_stat = b_issue && (wr_addr == OFS_WAKE_STAT);
    wire wr_irqsts = b_issue && (wr_addr == OFS_IRQSTS);
    wire wr_irqmsk = b_issue && (wr_addr == OFS_IRQMSK);

    wire ar_hs = s_axi_arvalid && arready_q;
    wire rvalid_d = (rvalid_q && !s_axi_rready) || ar_hs;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            if (aw_hs) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            awready_q <= !aw_held_d && !bvalid_d;
            wready_q <= !w_held_d && !bvalid_d;
            bvalid_q <= bvalid_d;
            if (b_issue) begin
                bresp_q <= known_ofs(wr_addr) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control and status flags

    logic rx_overrun_flag_q;
    logic rx_overrun_irq_enable_q;
    logic wakeup_enable_q;
    logic powerdown_block_option_q;
    logic wakeup_flag_q;
    logic wake_irq_enable_q;

    wire ovr_clr = (wr_buf_stat && wr_bits[BIT_RX_OVR]) ||
                   (wr_irqsts && wr_bits[BIT_IRQ_OVR]);
    wire wake_flag_clr = (wr_wake_stat && wr_bits[BIT_WK_FLAG]) ||
                         (wr_irqsts && wr_bits[BIT_IRQ_WAKE]);
    // set wins over a clear landing in the same cycle
    wire ovr_d = rx_overrun_evt || (rx_overrun_flag_q && !ovr_clr);
    wire ovien_d = wr_buf_ctl && wr_strb[1] ? wr_data[BIT_OVR_IEN] :
                   wr_irqmsk && wr_strb[0] ? wr_data[BIT_IRQ_OVR] : rx_overrun_irq_enable_q;

    ////////////////////////////////////////////////////////////////////////////
    // power sequencing

    logic wake_meta_q;
    logic wake_sync_q;
    ubw_pwr_e pwr_q;
    ubw_pwr_e pwr_d;

    wire wake_hit = (pwr_q == PWR_DOWN) && wake_sync_q && wakeup_enable_q;
    wire wake_flag_d = wake_hit || (wakeup_flag_q && !wake_flag_clr);
    wire abort_d = (pwr_q == PWR_RUN) && powerdown_req_i && transfer_active_i &&
                   !powerdown_block_option_q;

    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            PWR_RUN: begin
                if (powerdown_req_i) begin
                    // blocking only matters when a transfer is in flight
                    pwr_d = (transfer_active_i && powerdown_block_option_q) ?
                            PWR_IDLE : PWR_DOWN;
                end
            end
            PWR_IDLE: begin
                if (!transfer_active_i) begin
                    pwr_d = PWR_RUN;
                end
            end
            PWR_DOWN: begin
                if (wake_hit) begin
                    pwr_d = PWR_RUN;
                end
            end
            default: begin
                pwr_d = PWR_RUN;
            end
        endcase
    end

    wire [31:0] buf_stat_word = {22'h0, tx_buf_no_room, tx_buf_drained, 4'h0,
                               rx_overrun_flag_q, 1'b0, rx_buf_no_room, rx_buf_drained};
    wire [31:0] irqsts_word = {30'h0, wakeup_flag_q, rx_overrun_flag_q};
    wire [31:0] irqmsk_word = {30'h0, wake_irq_enable_q, rx_overrun_irq_enable_q};
    wire irq_d = |(irqsts_word & irqmsk_word);

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rx_overrun_flag_q <= 1'b0;
            rx_overrun_irq_enable_q <= 1'b0;
            wakeup_enable_q <= WAKE_CTL_RST[BIT_WK_EN];
            powerdown_block_option_q <= WAKE_CTL_RST[BIT_PD_BLOCK];
            wakeup_flag_q <= 1'b0;
            wake_irq_enable_q <= 1'b0;
            wake_meta_q <= 1'b0;
            wake_sync_q <= 1'b0;
            pwr_q <= PWR_RUN;
            irq_o <= 1'b0;
            powerdown_o <= 1'b0;
            idle_o <= 1'b0;
            transfer_abort_o <= 1'b0;
            chip_wake_o <= 1'b0;
        end else begin
            rx_overrun_flag_q <= ovr_d;
            rx_overrun_irq_enable_q <= ovien_d;
            if (wr_wake_ctl && wr_strb[0]) begin
                wakeup_enable_q <= wr_data[BIT_WK_EN];
                powerdown_block_option_q <= wr_data[BIT_PD_BLOCK];
            end
            wakeup_flag_q <= wake_flag_d;
            if (wr_irqmsk && wr_strb[0]) begin
                wake_irq_enable_q <= wr_data[BIT_IRQ_WAKE];
            end
            wake_meta_q <= wake_pin_i;
            wake_sync_q <= wake_meta_q;
            pwr_q <= pwr_d;
            irq_o <= irq_d;
            powerdown_o <= (pwr_d == PWR_DOWN);
            idle_o <= (pwr_d == PWR_IDLE);
            transfer_abort_o <= abort_d;
            chip_wake_o <= wake_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path

    wire [31:0] rd_word = (s_axi_araddr == OFS_BUF_CTL) ?
                              {17'h0, rx_overrun_irq_enable_q, 14'h0} :
                          (s_axi_araddr == OFS_BUF_STAT) ? buf_stat_word :
                          (s_axi_araddr == OFS_WAKE_CTL) ?
                              {29'h0, powerdown_block_option_q, 1'b0, wakeup_enable_q} :
                          (s_axi_araddr == OFS_WAKE_STAT) ? {31'h0, wakeup_flag_q} :
                          (s_axi_araddr == OFS_IRQSTS) ? irqsts_word :
                          (s_axi_araddr == OFS_IRQMSK) ? irqmsk_word : 32'h0000_0000;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else begin
            arready_q <= !rvalid_d;
            rvalid_q <= rvalid_d;
            if (ar_hs) begin
                rdata_q <= rd_word;
                rresp_q <= known_ofs(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_reset_status: assert property (@(posedge core_clk_i)
        reset_i |=> buf_stat_word == BUF_STAT_RST)
        else $error("status word wrong after reset");

    a_ovr_sticky: assert property (@(posedge core_clk_i) disable iff (reset_i)
        rx_overrun_flag_q && !ovr_clr |=> rx_overrun_flag_q)
        else $error("overrun flag dropped without a clear");

    a_ovr_w1c: assert property (@(posedge core_clk_i) disable iff (reset_i)
        wr_buf_stat && !wr_bits[BIT_RX_OVR] && !wr_irqsts && rx_overrun_flag_q
        |=> rx_overrun_flag_q)
        else $error("writing zero cleared the overrun flag");

    a_ovr_irq: assert property (@(posedge core_clk_i) disable iff (reset_i)
        rx_overrun_flag_q && rx_overrun_irq_enable_q |=> irq_o)
        else $error("overrun interrupt missing");

    a_pd_abort: assert property (@(posedge core_clk_i) disable iff (reset_i)
        pwr_q == PWR_RUN && powerdown_req_i && transfer_active_i && !powerdown_block_option_q
        |=> powerdown_o && transfer_abort_o && !idle_o)
        else $error("power-down did not abort the transfer");

    a_pd_block_idle: assert property (@(posedge core_clk_i) disable iff (reset_i)
        pwr_q == PWR_RUN && powerdown_req_i && transfer_active_i && powerdown_block_option_q
        |=> idle_o && !powerdown_o && !transfer_abort_o)
        else $error("blocked power-down did not go idle");

    a_wake_gated: assert property (@(posedge core_clk_i) disable iff (reset_i)
        pwr_q == PWR_DOWN && !wakeup_enable_q |=> pwr_q == PWR_DOWN && !chip_wake_o)
        else $error("woke with wake-up disabled");

    a_wake_flag: assert property (@(posedge core_clk_i) disable iff (reset_i)
        wake_hit |=> wakeup_flag_q && chip_wake_o && !powerdown_o)
        else $error("wake-up flag not set on wake");

    a_write_answer: assert property (@(posedge core_clk_i) disable iff (reset_i)
        b_issue |=> s_axi_bvalid)
        else $error("write response late");

endmodule // ubw_status_wakeup

// ### tb_ubw_status_wakeup.sv
`timescale 1ns/1ps
module tb_ubw_status_wakeup;
    import ubw_pkg::*;

    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic s_axi_awvalid = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_wvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_rready = 1'b0;
    logic tx_push_i = 1'b0;
    logic tx_pop_i = 1'b0;
    logic rx_push_i = 1'b0;
    logic rx_pop_i = 1'b0;
    logic powerdown_req_i = 1'b0;
    logic transfer_active_i = 1'b0;
    logic wake_pin_i = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic irq_o, powerdown_o, idle_o, transfer_abort_o, chip_wake_o;
    int fail_count = 0;
    int total_checks = 0;
    int abort_cnt = 0;
    int wake_cnt = 0;
    logic [33:0] exp_r[$];
    logic [1:0] exp_b[$];

    always #50 core_clk_i = ~core_clk_i;

    ubw_status_wakeup DUT (
        .core_clk_i(core_clk_i), .reset_i(reset_i),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .tx_push_i(tx_push_i), .tx_pop_i(tx_pop_i), .rx_push_i(rx_push_i),
        .rx_pop_i(rx_pop_i), .powerdown_req_i(powerdown_req_i),
        .transfer_active_i(transfer_active_i), .wake_pin_i(wake_pin_i), .irq_o(irq_o),
        .powerdown_o(powerdown_o), .idle_o(idle_o), .transfer_abort_o(transfer_abort_o),
        .chip_wake_o(chip_wake_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // monitor: the oldest note is matched to each response as it is taken
    always @(posedge core_clk_i) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            if (exp_r.size() == 0) check("read unexpected", {s_axi_rresp, s_axi_rdata},
                                         34'h3_FFFF_FFFF);
            else check("read data", {s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
        end
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
            if (exp_b.size() == 0) check("write unexpected", {32'h0, s_axi_bresp}, 34'h3);
            else check("write resp", {32'h0, s_axi_bresp}, {32'h0, exp_b.pop_front()});
        end
        if (transfer_abort_o === 1'b1) abort_cnt++;
        if (chip_wake_o === 1'b1) wake_cnt++;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    // write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
        logic aw_open, w_open;
        aw_open = 1'b1;
        w_open = 1'b1;
        exp_b.push_back(rsp);
        @(posedge core_clk_i);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge core_clk_i);
            if (aw_open && s_axi_awready === 1'b1) begin
                aw_open = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_open && s_axi_wready === 1'b1) begin
                w_open = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid === 1'b1) break;
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] exp);
        exp_r.push_back(exp);
        @(posedge core_clk_i);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        do @(posedge core_clk_i); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge core_clk_i);
        s_axi_rready <= 1'b0;
    endtask

    // one-cycle event pulses: {tx_push, tx_pop, rx_push, rx_pop, powerdown_req}
    task automatic pulse(input logic [4:0] v, input int times);
        repeat (times) begin
            @(posedge core_clk_i);
            {tx_push_i, tx_pop_i, rx_push_i, rx_pop_i, powerdown_req_i} <= v;
            @(posedge core_clk_i);
            {tx_push_i, tx_pop_i, rx_push_i, rx_pop_i, powerdown_req_i} <= 5'b0;
        end
        idle(3);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(100 * 20000);
        fail_count++;
        give_verdict();
    end

    initial begin
        int n;
        logic [31:0] r;
        r = $urandom(32'h52C7);
        idle(5);
        reset_i <= 1'b0;
        rd(OFS_BUF_STAT, {RESP_OKAY, BUF_STAT_RST});
        rd(OFS_WAKE_CTL, {RESP_OKAY, WAKE_CTL_RST});
        pulse(5'b10000, BUF_DEPTH);
        rd(OFS_BUF_STAT, {RESP_OKAY, 32'h0000_0201});
        pulse(5'b10000, 1);
        rd(OFS_BUF_STAT, {RESP_OKAY, 32'h0000_0201});
        pulse(5'b01000, 1);
        rd(OFS_BUF_STAT, {RESP_OKAY, 32'h0000_0001});
        pulse(5'b01000, 2);
        rd(OFS_BUF_STAT, {RESP_OKAY, 32'h0000_0101});
        pulse(5'b00100, 1);
        rd(OFS_BUF_STAT, {RESP_OKAY, 32'h0000_0100});
        pulse(5'b00100, 1);
        rd(OFS_BUF_STAT, {RESP_OKAY, 32'h0000_0102});
        // a word arriving on a full buffer must flag, not overwrite the level
        pulse(5'b00100, 1);
        rd(OFS_BUF_STAT, {RESP_OKAY, 32'h0000_010A});
        check("irq masked", irq_o, 34'h0);
        wr(OFS_BUF_STAT, 32'h0000_0000, RESP_OKAY);
        rd(OFS_BUF_STAT, {RESP_OKAY, 32'h0000_010A});
        wr(OFS_BUF_CTL, 32'h0000_4000, RESP_OKAY);
        rd(OFS_BUF_CTL, {RESP_OKAY, 32'h0000_4000});
        idle(3);
        check("irq overrun", irq_o, 34'h1);
        wr(OFS_BUF_STAT, 32'h0000_0008, RESP_OKAY);
        idle(3);
        check("irq cleared", irq_o, 34'h0);
        rd(OFS_BUF_STAT, {RESP_OKAY, 32'h0000_0102});
        pulse(5'b00010, 2);
        rd(OFS_BUF_STAT, {RESP_OKAY, 32'h0000_0101});
        wr(OFS_WAKE_CTL, r, RESP_OKAY);
        rd(OFS_WAKE_CTL, {RESP_OKAY, r & 32'h0000_0005});
        wr(OFS_WAKE_CTL, 32'h0000_0000, RESP_OKAY);
        rd(8'h10, {RESP_SLVERR, 32'h0000_0000});
        wr(8'h10, 32'hFFFF_FFFF, RESP_SLVERR);
        // power-down during a transfer with blocking off
        transfer_active_i <= 1'b1;
        pulse(5'b00001, 1);
        check("powerdown", powerdown_o, 34'h1);
        check("idle", idle_o, 34'h0);
        check("abort count", abort_cnt, 34'h1);
        transfer_active_i <= 1'b0;
        wake_pin_i <= 1'b1;
        idle(12);
        check("no wake disabled", powerdown_o, 34'h1);
        check("wake count off", wake_cnt, 34'h0);
        wr(OFS_WAKE_CTL, 32'h0000_0001, RESP_OKAY);
        for (n = 0; n < 20 && powerdown_o !== 1'b0; n++) @(posedge core_clk_i);
        // let the monitor count the wake pulse before it is compared
        idle(1);
        check("woken", powerdown_o, 34'h0);
        check("wake count", wake_cnt, 34'h1);
        wake_pin_i <= 1'b0;
        rd(OFS_WAKE_STAT, {RESP_OKAY, 32'h0000_0001});
        rd(OFS_IRQSTS, {RESP_OKAY, 32'h0000_0002});
        wr(OFS_IRQSTS, 32'h0000_0001, RESP_OKAY);
        rd(OFS_WAKE_STAT, {RESP_OKAY, 32'h0000_0001});
        wr(OFS_IRQMSK, 32'h0000_0002, RESP_OKAY);
        idle(3);
        check("irq wake", irq_o, 34'h1);
        wr(OFS_WAKE_STAT, 32'h0000_0001, RESP_OKAY);
        idle(3);
        check("irq wake clr", irq_o, 34'h0);
        rd(OFS_WAKE_STAT, {RESP_OKAY, 32'h0000_0000});
        // blocking on: transfer keeps running and chip only idles
        wr(OFS_WAKE_CTL, 32'h0000_0004, RESP_OKAY);
        transfer_active_i <= 1'b1;
        pulse(5'b00001, 1);
        check("idle entered", idle_o, 34'h1);
        check("no powerdown", powerdown_o, 34'h0);
        check("no abort", abort_cnt, 34'h1);
        transfer_active_i <= 1'b0;
        idle(4);
        check("idle left", idle_o, 34'h0);
        check("queues drained", exp_r.size() + exp_b.size(), 34'h0);
        give_verdict();
    end
endmodule // tb_ubw_status_wakeup
